// ==== hw/iepec_map.svh ====
// register offsets, field positions and reset values of the irq block
// assumes byte addresses on a 12-bit register port
`ifndef IEPEC_MAP_SVH
`define IEPEC_MAP_SVH
`define IEPEC_ADDR_W 12
`define IEPEC_REQ1_OFF 12'hFC3
`define IEPEC_EN1H_OFF 12'hFC4
`define IEPEC_EN1L_OFF 12'hFC5
`define IEPEC_REQ2_OFF 12'hFC6
`define IEPEC_EN2H_OFF 12'hFC7
`define IEPEC_EN2L_OFF 12'hFC8
`define IEPEC_EDGE_OFF 12'hFCD
`define IEPEC_SSEL_OFF 12'hFCE
`define IEPEC_CTL_OFF 12'hFCF
`define IEPEC_IRQST_OFF 12'hFD0
`define IEPEC_IRQMSK_OFF 12'hFD1
`define IEPEC_MIE_BIT 7
`define IEPEC_LVSEL_BIT 7
`define IEPEC_CMPSEL_BIT 6
`define IEPEC_BANK2_MASK 8'h0F
`define IEPEC_SSEL_MASK 8'hC0
`define IEPEC_RESET_VAL 8'h00
`endif

// ==== hw/iepec_pkg.sv ====
// types shared by the irq enable/priority block
package iepec_pkg;
  typedef logic [1:0] iepec_level_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iepec_bus_t;
  typedef struct packed {
    logic valid;
    logic bank;
    logic [2:0] index;
    iepec_level_t level;
  } iepec_pick_t;
endpackage

// ==== hw/iepec_sync.sv ====
// two-flop synchroniser for asynchronous source levels
// assumes one clock domain, async active low reset
`timescale 1ns/100ps
module iepec_sync
  import iepec_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } iepec_sync_state_t;
  iepec_sync_state_t state;
  iepec_sync_state_t next_state;

  always_comb
  begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign sync_out = state.stable;
endmodule // iepec_sync

// ==== hw/iepec_ctrl.sv ====
// interrupt enable, priority, edge and shared-source control
// assumes pins and analog events are asynchronous; core acks on same clock
//
// Notes on behaviour
// RULE1 - bank one level from high/low bits
// RULE2 - bank one high enable register at FC4
// RULE3 - bank one low enable register at FC5
// RULE4 - bank two same two-bit level coding
// RULE5 - bank two high enable at FC7
// RULE6 - bank two low enable at FC8
// RULE7 - software writes reserved bits as zero
// RULE8 - edge select: zero falling, one rising
// RULE9 - shared bit7: pin seven or low-voltage
// RULE10 - shared bit6: pin six or comparator
// RULE11 - source switch may itself raise request
// RULE12 - software disables before switching source
// RULE13 - master enable in control bit seven
// RULE14 - set by on, return or write
// RULE15 - cleared by off, ack, reset, write
// RULE16 - detected request sets sticky pending bit
// RULE17 - master enable gates request to core
// RULE18 - highest level wins, fixed tie order
// RULE19 - control bits six..zero read zero
`timescale 1ns/100ps
`include "iepec_map.svh"
module iepec_ctrl
  import iepec_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] port_a_pin,
  input wire logic [3:0] port_c_pin,
  input wire logic low_voltage_detector,
  input wire logic comparator_out,
  input wire logic interrupts_on_instruction,
  input wire logic interrupts_off_instruction,
  input wire logic return_from_handler_instruction,
  input wire logic core_ack,
  output logic core_irq,
  output logic core_irq_bank,
  output logic [2:0] core_irq_index,
  output logic [1:0] core_irq_level,
  output logic irq_out
);
  typedef struct packed {
    logic [7:0] en1h;
    logic [7:0] en1l;
    logic [3:0] en2h;
    logic [3:0] en2l;
    logic [7:0] edge_sel;
    logic [1:0] ssel;
    logic mie;
    logic [7:0] req1;
    logic [3:0] req2;
    logic [7:0] last1;
    logic [3:0] last2;
    logic [2:0] primed;
    logic [1:0] irq_st;
    logic [1:0] irq_msk;
    logic [7:0] rdata;
    iepec_pick_t pick;
  } iepec_state_t;

  iepec_state_t state;
  iepec_state_t next_state;
  logic [13:0] raw_async;
  logic [13:0] raw_sync;
  logic [7:0] src1;
  logic [3:0] src2;

  assign raw_async = {comparator_out, low_voltage_detector,
                      port_c_pin, port_a_pin};

  iepec_sync #(.WIDTH(14)) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(raw_async),
    .sync_out(raw_sync)
  );

  // bank two (port c) edge select reuses edge bits 3..0
  function automatic iepec_level_t level_of(input logic hi, input logic lo);
    level_of = {hi, lo}; // [RULE1] [RULE4]
  endfunction

  function automatic logic edge_hit(input logic prev, input logic now,
                                    input logic rising);
    edge_hit = rising ? (now & ~prev) : (prev & ~now); // [RULE8]
  endfunction

  // shared source mux sits ahead of edge detection, so a switch is an edge
  always_comb
  begin
    src1 = raw_sync[7:0];
    if (state.ssel[1])
      src1[7] = raw_sync[12]; // [RULE9]
    if (state.ssel[0])
      src1[6] = raw_sync[13]; // [RULE10]
    src2 = raw_sync[11:8];
  end

  always_comb
  begin
    logic [7:0] hit1;
    logic [3:0] hit2;
    logic wsel;
    logic rsel;
    iepec_level_t lv;
    iepec_pick_t best;
    hit1 = '0;
    hit2 = '0;
    wsel = 1'b0;
    rsel = 1'b0;
    lv = '0;
    best = '0;
    next_state = state;
    next_state.last1 = src1;
    next_state.last2 = src2;
    next_state.primed = {state.primed[1:0], 1'b1};
    // two sync stages plus one seed cycle must pass before edges count,
    // else the first real pin level looks like an edge against reset zeros
    if (state.primed[2])
    begin
      for (int i = 0; i < 8; i++)
        hit1[i] = edge_hit(state.last1[i], src1[i],
                           state.edge_sel[i]); // [RULE11]
      for (int i = 0; i < 4; i++)
        hit2[i] = edge_hit(state.last2[i], src2[i], state.edge_sel[i]);
    end

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        `IEPEC_REQ1_OFF: next_state.req1 = state.req1 & ~reg_wdata;
        `IEPEC_REQ2_OFF: next_state.req2 = state.req2 & ~reg_wdata[3:0];
        `IEPEC_EN1H_OFF: next_state.en1h = reg_wdata; // [RULE2]
        `IEPEC_EN1L_OFF: next_state.en1l = reg_wdata; // [RULE3]
        `IEPEC_EN2H_OFF: next_state.en2h = reg_wdata[3:0]; // [RULE5]
        `IEPEC_EN2L_OFF: next_state.en2l = reg_wdata[3:0]; // [RULE6]
        `IEPEC_EDGE_OFF: next_state.edge_sel = reg_wdata;
        `IEPEC_SSEL_OFF:
        begin
          next_state.ssel = {reg_wdata[`IEPEC_LVSEL_BIT],
                             reg_wdata[`IEPEC_CMPSEL_BIT]};
          wsel = 1'b1;
        end
        `IEPEC_CTL_OFF:
          next_state.mie = reg_wdata[`IEPEC_MIE_BIT]; // [RULE14] [RULE15]
        `IEPEC_IRQST_OFF: next_state.irq_st = state.irq_st & ~reg_wdata[1:0];
        `IEPEC_IRQMSK_OFF: next_state.irq_msk = reg_wdata[1:0];
        default: next_state = next_state;
      endcase
    end

    // instructions beat a same-cycle write; ack and off win over on
    if (interrupts_on_instruction || return_from_handler_instruction)
      next_state.mie = 1'b1; // [RULE14]
    if (interrupts_off_instruction || core_ack)
      next_state.mie = 1'b0; // [RULE15]

    // ack clears the presented request; a new edge still sets it
    if (core_ack && state.pick.valid)
    begin
      if (state.pick.bank)
        next_state.req2[state.pick.index[1:0]] = 1'b0;
      else
        next_state.req1[state.pick.index] = 1'b0;
    end
    next_state.req1 = next_state.req1 | hit1; // [RULE16]
    next_state.req2 = next_state.req2 | hit2; // [RULE16]

    // fixed order: bank one before two, lower index first in bank one, higher index first in bank two
    for (int i = 7; i >= 0; i--)
    begin
      lv = level_of(state.en1h[i], state.en1l[i]);
      if (state.req1[i] && lv != 2'b00 && lv >= best.level)
        best = '{valid: 1'b1, bank: 1'b0, index: 3'(i), level: lv};
    end
    for (int i = 3; i >= 0; i--)
    begin
      lv = level_of(state.en2h[i], state.en2l[i]);
      if (state.req2[i] && lv != 2'b00 && lv > best.level)
        best = '{valid: 1'b1, bank: 1'b1, index: 3'(i), level: lv};
    end
    next_state.pick = best; // [RULE18]

    // sticky status: bit0 any new request, bit1 source switch; set wins
    next_state.irq_st[0] = next_state.irq_st[0] | (|hit1) | (|hit2);
    next_state.irq_st[1] = next_state.irq_st[1] | wsel;

    // read data, one cycle later
    rsel = reg_rd;
    next_state.rdata = '0;
    if (rsel)
    begin
      case (reg_addr)
        `IEPEC_REQ1_OFF: next_state.rdata = state.req1;
        `IEPEC_REQ2_OFF: next_state.rdata = {4'h0, state.req2};
        `IEPEC_EN1H_OFF: next_state.rdata = state.en1h;
        `IEPEC_EN1L_OFF: next_state.rdata = state.en1l;
        `IEPEC_EN2H_OFF: next_state.rdata = {4'h0, state.en2h};
        `IEPEC_EN2L_OFF: next_state.rdata = {4'h0, state.en2l};
        `IEPEC_EDGE_OFF: next_state.rdata = state.edge_sel;
        `IEPEC_SSEL_OFF: next_state.rdata = {state.ssel, 6'h00};
        `IEPEC_CTL_OFF: next_state.rdata = {state.mie, 7'h00}; // [RULE13] [RULE19]
        `IEPEC_IRQST_OFF: next_state.rdata = {6'h00, state.irq_st};
        `IEPEC_IRQMSK_OFF: next_state.rdata = {6'h00, state.irq_msk};
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= '0; // [RULE15]
    else
      state <= next_state;
  end

  assign reg_rdata = state.rdata;
  assign core_irq = state.mie & state.pick.valid; // [RULE17]
  assign core_irq_bank = state.pick.bank;
  assign core_irq_index = state.pick.index;
  assign core_irq_level = state.pick.level;
  assign irq_out = |(state.irq_st & state.irq_msk);
endmodule // iepec_ctrl

// ==== tb/iepec_ctrl_props.sv ====
// port checks for the irq enable/priority control block
// assumes one core_clk domain and async active low arst_n
`timescale 1ns/100ps
module iepec_ctrl_props
  import iepec_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic interrupts_on_instruction,
  input wire logic interrupts_off_instruction,
  input wire logic return_from_handler_instruction,
  input wire logic core_ack,
  input wire logic core_irq,
  input wire logic [1:0] core_irq_level
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  wire rd_ctl = reg_rd && reg_addr == 12'hFCF;
  wire rd_ss = reg_rd && reg_addr == 12'hFCE;
  wire rd_b2 = reg_rd && (reg_addr == 12'hFC7 || reg_addr == 12'hFC8);
  wire off_ev = core_ack || interrupts_off_instruction;
  wire on_ev = interrupts_on_instruction || return_from_handler_instruction;
  property p_ack_irq; core_ack |=> !core_irq; endproperty
  a_ack_irq: assert property (p_ack_irq) else $error("irq after ack");
  property p_off_irq; interrupts_off_instruction |=> !core_irq; endproperty
  a_off_irq: assert property (p_off_irq) else $error("irq after off");
  property p_off_rd; off_ev ##1 rd_ctl |=> reg_rdata == 8'h00; endproperty
  a_off_rd: assert property (p_off_rd) else $error("enable kept");
  property p_on_rd; on_ev && !off_ev ##1 rd_ctl |=> reg_rdata == 8'h80; endproperty
  a_on_rd: assert property (p_on_rd) else $error("enable not set");
  property p_ctl_res; rd_ctl |=> reg_rdata[6:0] == 7'h00; endproperty
  a_ctl_res: assert property (p_ctl_res) else $error("ctl reserved");
  property p_bank2; rd_b2 |=> reg_rdata[7:4] == 4'h0; endproperty
  a_bank2: assert property (p_bank2) else $error("bank two reserved");
  property p_ssel; rd_ss |=> reg_rdata[5:0] == 6'h00; endproperty
  a_ssel: assert property (p_ssel) else $error("select reserved");
  property p_level; core_irq |-> core_irq_level != 2'b00; endproperty
  a_level: assert property (p_level) else $error("disabled pick");
  c_ack: cover property (core_ack);
  c_on: cover property (on_ev ##1 rd_ctl);
  c_irq: cover property (core_irq ##1 !core_irq);
endmodule // iepec_ctrl_props
bind iepec_ctrl iepec_ctrl_props i_props (.core_clk, .arst_n, .reg_addr,
  .reg_rd, .reg_rdata, .interrupts_on_instruction, .interrupts_off_instruction,
  .return_from_handler_instruction, .core_ack, .core_irq, .core_irq_level);

// ==== tb/iepec_core_model.sv ====
// core model: acks a presented request ack_dly+1 cycles after core_irq rises
// assumes core_irq from the control block on the same clock
`timescale 1ns/100ps
module iepec_core_model
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic core_irq,
  input wire logic [3:0] ack_dly,
  output logic core_ack
);
  logic [3:0] cnt;
  // no second ack while the first is still taking effect
  wire hit = core_irq && !core_ack;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt <= 4'h0;
      core_ack <= 1'b0;
    end
    else
    begin
      core_ack <= hit && cnt == ack_dly;
      cnt <= (hit && cnt != ack_dly) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // iepec_core_model

// ==== tb/test_irq_enable_priority_edge_ctrl.sv ====
// self-checking bench for the irq enable/priority control block
// assumes the core model acks every presented request
`timescale 1ns/100ps
module test_irq_enable_priority_edge_ctrl
  import iepec_pkg::*;
;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] ins = 3'h0;
  logic [7:0] pa = 8'hFF;
  logic [3:0] pc = 4'h0;
  logic [3:0] dly = 4'h0;
  logic [7:0] reg_rdata;
  logic core_ack, core_irq, core_irq_bank, irq_out;
  logic [2:0] core_irq_index;
  logic [1:0] core_irq_level;
  int error_cnt = 0;
  int checked = 0;
  logic [11:0] ra [7] = '{12'hFC4, 12'hFC5, 12'hFC7, 12'hFC8, 12'hFCD,
    12'hFCE, 12'hFCF};
  logic [7:0] rb [7] = '{8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'hC0, 8'h80};
  logic [2:0] iv [5] = '{3'h2, 3'h1, 3'h2, 3'h4, 3'h3};
  logic [7:0] ie [5] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
  iepec_ctrl i_iepec_ctrl (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .port_a_pin(pa), .port_c_pin(pc),
    .low_voltage_detector(1'b0), .comparator_out(1'b0),
    .interrupts_on_instruction(ins[0]), .interrupts_off_instruction(ins[1]),
    .return_from_handler_instruction(ins[2]), .core_ack, .core_irq,
    .core_irq_bank, .core_irq_index, .core_irq_level, .irq_out);
  iepec_core_model i_iepec_core_model (.core_clk, .arst_n, .core_irq,
    .ack_dly(dly), .core_ack);
  initial forever #2 core_clk = ~core_clk;
  task automatic print_verdict;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobe stays up so writes can run back to back
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic nap(input int n);
    reg_wr <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    reg_wr <= 1'b0;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    chk(reg_rdata, e);
  endtask
  task automatic go(input logic [2:0] v);
    reg_wr <= 1'b0;
    ins <= v;
    @(posedge core_clk);
    ins <= 3'h0;
  endtask
  task automatic pick(input logic [7:0] e);
    for (int i = 0; i < 20 && core_irq !== 1'b1; i++)
      @(posedge core_clk);
    chk({2'h0, core_irq_bank, core_irq_index, core_irq_level}, e);
    repeat (8) @(posedge core_clk);
    chk({7'h00, core_irq}, 8'h00);
  endtask
  initial
  begin
    repeat (2000) @(posedge core_clk);
    error_cnt++;
    print_verdict;
  end
  initial
  begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    foreach (ra[i]) rd(ra[i], 8'h00);
    foreach (ra[i]) wr(ra[i], 8'hFF);
    wr(12'hFC9, 8'hFF);
    foreach (ra[i]) rd(ra[i], rb[i]);
    rd(12'hFC9, 8'h00);
    foreach (iv[i])
    begin
      go(iv[i]);
      rd(12'hFCF, ie[i]);
    end
    wr(12'hFC4, 8'h01);
    wr(12'hFC5, 8'h00);
    wr(12'hFC7, 8'h08);
    wr(12'hFC8, 8'h08);
    wr(12'hFCD, 8'h08);
    wr(12'hFCE, 8'h00);
    nap(8);
    pa[0] <= 1'b0;
    pc[3] <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({7'h00, core_irq}, 8'h00);
    rd(12'hFC6, 8'h08);
    dly <= 4'h3;
    wr(12'hFCF, 8'h80);
    nap(1);
    pick(8'h2F);
    go(3'h1);
    pick(8'h02);
    rd(12'hFCF, 8'h00);
    wr(12'hFCE, 8'h80);
    nap(6);
    rd(12'hFC3, 8'h80);
    wr(12'hFCE, 8'hC0);
    nap(6);
    rd(12'hFC3, 8'hC0);
    chk({7'h00, irq_out}, 8'h00);
    rd(12'hFD0, 8'h03);
    wr(12'hFD1, 8'h03);
    nap(2);
    chk({7'h00, irq_out}, 8'h01);
    wr(12'hFD0, 8'h03);
    nap(2);
    chk({7'h00, irq_out}, 8'h00);
    rd(12'hFD0, 8'h00);
    print_verdict;
  end
endmodule // test_irq_enable_priority_edge_ctrl
